// file: rtl/csr_access_regs.svh
// Register indices, field positions, reset values and timing counts
// for the indirect register access block and its line monitor.
// Assumes a 125 MHz controller clock and a 10 Mb/s network bit rate.
`ifndef CSR_ACCESS_REGS_SVH
`define CSR_ACCESS_REGS_SVH

// ----------------------------------------------------------------------
// Index port and host port select codes
// ----------------------------------------------------------------------
`define INDEX_W 7
`define INDEX_RST 7'h00
`define PORT_INDEX 2'h0
`define PORT_MAIN 2'h1
`define PORT_CONFIG 2'h2

// ----------------------------------------------------------------------
// Register indices behind the main data port
// ----------------------------------------------------------------------
`define IDX_STATUS_COMMAND 7'h00
`define IDX_MASK 7'h03

// ----------------------------------------------------------------------
// Status/command field positions
// ----------------------------------------------------------------------
`define B_ERR 15
`define B_BABBLE 14
`define B_COLL 13
`define B_MISSED 12
`define B_MEMERR 11
`define B_RXEVT 10
`define B_TXEVT 9
`define B_SETUP 8
`define B_IRQ_FLAG 7
`define B_IRQ_EN 6
`define B_RX_ACTIVE 5
`define B_TX_ACTIVE 4
`define B_DEMAND 3
`define B_STOP 2
`define B_RUN 1
`define B_SETUP_REQ 0

// ----------------------------------------------------------------------
// Mask register: writable bit positions and reset value
// ----------------------------------------------------------------------
`define MASK_WR 16'h5F00
`define MASK_RST 16'h0000

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 8
`define BIT_TIME_NS 100
`define SQE_WINDOW_BITS 20
`define SQE_WINDOW_NS (`SQE_WINDOW_BITS * `BIT_TIME_NS)
`define SQE_CYC ((`SQE_WINDOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DMA_TIMEOUT_NS 50000
`define DMA_TIMEOUT_CYC ((`DMA_TIMEOUT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BABBLE_BYTES 1519

`endif

// file: rtl/csr_access_pkg.sv
// Types used by the register access block.
// Assumes the constants of csr_access_regs.svh.
package csr_access_pkg;

  // ----------------------------------------------------------------------
  // Run state of the controller
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_STOPPED = 2'b00,
    ST_SETUP = 2'b01,
    ST_READY = 2'b10,
    ST_RUNNING = 2'b11
  } run_state_t;

endpackage

// file: rtl/line_event_if.sv
// Error events raised by the line monitor toward the status register.
// Babble and memory error are one-cycle pulses in the controller clock domain; collision error also stays high while transmitting with link fail.
`timescale 1ns/1ps
interface line_event_if;
  logic babble;
  logic coll_err;
  logic mem_err;
  modport mon (output babble, output coll_err, output mem_err);
  modport reg_side (input babble, input coll_err, input mem_err);
endinterface

// file: rtl/line_monitor.sv
// Watches transmit length, the collision test window and bus-master
// grant latency, and raises error events on the line event interface.
// Assumes all inputs are synchronous to i_clk.
`timescale 1ns/1ps
`include "csr_access_regs.svh"
module line_monitor #(
  parameter int DMA_TIMEOUT_CYC = `DMA_TIMEOUT_CYC
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_tx_byte,
  input wire logic i_tx_end,
  input wire logic i_transmitting,
  input wire logic i_aui_sel,
  input wire logic i_aui_col,
  input wire logic i_tp_link_fail,
  input wire logic i_dma_req,
  input wire logic i_dma_ack,
  line_event_if.mon evt
);

  localparam logic [10:0] BABBLE_LAST = 11'(`BABBLE_BYTES - 1);
  localparam logic [8:0] SQE_LAST = 9'(`SQE_CYC - 1);
  localparam logic [15:0] DMA_LAST = 16'(DMA_TIMEOUT_CYC - 1);

  logic [10:0] byte_cnt_ff, nxt_byte_cnt;
  logic babble_done_ff, nxt_babble_done;
  logic [8:0] sqe_cnt_ff, nxt_sqe_cnt;
  logic sqe_wait_ff, nxt_sqe_wait;
  logic [15:0] dma_cnt_ff, nxt_dma_cnt;
  logic dma_done_ff, nxt_dma_done;
  logic babble_ev, sqe_ev, dma_ev;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_byte_cnt = byte_cnt_ff;
    nxt_babble_done = babble_done_ff;
    babble_ev = 1'b0;
    if (i_tx_end) begin
      nxt_byte_cnt = 11'h000;
      nxt_babble_done = 1'b0;
    end else if (i_tx_byte && !babble_done_ff) begin
      // The count stops once a frame has babbled so it cannot wrap.
      if (byte_cnt_ff == BABBLE_LAST) begin
        babble_ev = 1'b1;
        nxt_babble_done = 1'b1;
      end else begin
        nxt_byte_cnt = byte_cnt_ff + 11'h001;
      end
    end

    nxt_sqe_cnt = sqe_cnt_ff;
    nxt_sqe_wait = sqe_wait_ff;
    sqe_ev = 1'b0;
    if (i_tx_end && i_aui_sel) begin
      nxt_sqe_wait = 1'b1;
      nxt_sqe_cnt = 9'h000;
    end else if (sqe_wait_ff) begin
      if (i_aui_col) begin
        nxt_sqe_wait = 1'b0;
      end else if (sqe_cnt_ff == SQE_LAST) begin
        sqe_ev = 1'b1;
        nxt_sqe_wait = 1'b0;
      end else begin
        nxt_sqe_cnt = sqe_cnt_ff + 9'h001;
      end
    end

    nxt_dma_cnt = dma_cnt_ff;
    nxt_dma_done = dma_done_ff;
    dma_ev = 1'b0;
    if (!i_dma_req || i_dma_ack) begin
      nxt_dma_cnt = 16'h0000;
      nxt_dma_done = 1'b0;
    end else if (!dma_done_ff) begin
      if (dma_cnt_ff == DMA_LAST) begin
        dma_ev = 1'b1;
        nxt_dma_done = 1'b1;
      end else begin
        nxt_dma_cnt = dma_cnt_ff + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      byte_cnt_ff <= 11'h000;
      babble_done_ff <= 1'b0;
      sqe_cnt_ff <= 9'h000;
      sqe_wait_ff <= 1'b0;
      dma_cnt_ff <= 16'h0000;
      dma_done_ff <= 1'b0;
    end else begin
      byte_cnt_ff <= nxt_byte_cnt;
      babble_done_ff <= nxt_babble_done;
      sqe_cnt_ff <= nxt_sqe_cnt;
      sqe_wait_ff <= nxt_sqe_wait;
      dma_cnt_ff <= nxt_dma_cnt;
      dma_done_ff <= nxt_dma_done;
    end
  end

  assign evt.babble = babble_ev;
  assign evt.coll_err = sqe_ev || (i_transmitting && i_tp_link_fail);
  assign evt.mem_err = dma_ev;

endmodule

// file: rtl/indirect_csr_status_access.sv
// Indirect host register access with the status/command and mask
// registers. Other register indices are forwarded on the external ports.
// Assumes host strobes are one-cycle pulses synchronous to i_clk.
`timescale 1ns/1ps
`include "csr_access_regs.svh"
module indirect_csr_status_access #(
  parameter int DMA_TIMEOUT_CYC = `DMA_TIMEOUT_CYC
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [1:0] i_port_sel,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_rdata,
  output logic o_rd_valid,
  output logic [6:0] o_ext_index,
  output logic o_ext_csr_wr,
  output logic o_ext_csr_rd,
  input wire logic [15:0] i_ext_csr_rdata,
  output logic o_cfg_wr,
  output logic o_cfg_rd,
  input wire logic [15:0] i_cfg_rdata,
  output logic [15:0] o_ext_wdata,
  input wire logic i_tx_byte,
  input wire logic i_tx_end,
  input wire logic i_transmitting,
  input wire logic i_aui_sel,
  input wire logic i_aui_col,
  input wire logic i_tp_link_fail,
  input wire logic i_dma_req,
  input wire logic i_dma_ack,
  input wire logic i_rx_discard,
  input wire logic i_rx_done,
  input wire logic i_tx_done,
  input wire logic i_setup_read_done,
  input wire logic i_tx_desc_fetch,
  input wire logic i_other_irq,
  input wire logic i_receive_disable,
  input wire logic i_transmit_disable,
  output logic o_setup_req,
  output logic o_running,
  output logic o_stopped,
  output logic o_tx_poll_now,
  output logic o_irq
);

  logic [6:0] index_ff, nxt_index;
  logic [15:0] mask_ff, nxt_mask;
  logic babble_ff, nxt_babble, coll_ff, nxt_coll, missed_ff, nxt_missed;
  logic memerr_ff, nxt_memerr, rxevt_ff, nxt_rxevt, txevt_ff, nxt_txevt;
  logic setup_ff, nxt_setup, irq_flag_ff, nxt_irq_flag, irq_en_ff, nxt_irq_en;
  logic rx_active_ff, nxt_rx_active, tx_active_ff, nxt_tx_active, tx_demand_ff, nxt_tx_demand;
  logic stop_ff, nxt_stop, run_ff, nxt_run, setup_req_ff, nxt_setup_req;
  logic start_pend_ff, nxt_start_pend;
  csr_access_pkg::run_state_t state_ff, nxt_state;
  logic [15:0] rdata_ff, nxt_rdata;
  logic rd_valid_ff;
  logic wr_main, rd_main, wr_status, wr_mask, wr_ext, rd_ext;
  logic stop_w, run_w, setup_w, stop_now, go_run;
  logic err_sum, irq_src;
  logic [15:0] status_word;

  line_event_if evt ();

  line_monitor #(
    .DMA_TIMEOUT_CYC(DMA_TIMEOUT_CYC)
  ) u_line_monitor (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_tx_byte(i_tx_byte),
    .i_tx_end(i_tx_end),
    .i_transmitting(i_transmitting),
    .i_aui_sel(i_aui_sel),
    .i_aui_col(i_aui_col),
    .i_tp_link_fail(i_tp_link_fail),
    .i_dma_req(i_dma_req),
    .i_dma_ack(i_dma_ack),
    .evt(evt)
  );

  // Sticky flag update: a hardware event wins over a same-cycle clear,
  // but stop clears everything since the controller is being halted.
  function automatic logic flag_next(input logic cur, input logic set,
                                     input logic clr, input logic stop);
    if (stop) begin
      flag_next = 1'b0;
    end else if (set) begin
      flag_next = 1'b1;
    end else if (clr) begin
      flag_next = 1'b0;
    end else begin
      flag_next = cur;
    end
  endfunction

  // ----------------------------------------------------------------------
  // Port decode
  // ----------------------------------------------------------------------
  always_comb begin
    wr_main = i_wr && (i_port_sel == `PORT_MAIN);
    rd_main = i_rd && (i_port_sel == `PORT_MAIN);
    wr_status = wr_main && (index_ff == `IDX_STATUS_COMMAND);
    wr_mask = wr_main && (index_ff == `IDX_MASK);
    wr_ext = wr_main && (index_ff != `IDX_STATUS_COMMAND) && (index_ff != `IDX_MASK);
    rd_ext = rd_main && (index_ff != `IDX_STATUS_COMMAND) && (index_ff != `IDX_MASK);
    stop_w = wr_status && i_wdata[`B_STOP];
    run_w = wr_status && i_wdata[`B_RUN] && !i_wdata[`B_STOP];
    setup_w = wr_status && i_wdata[`B_SETUP_REQ] && !i_wdata[`B_STOP];
    stop_now = stop_w;
  end

  assign o_ext_index = index_ff;
  assign o_ext_wdata = i_wdata;
  assign o_ext_csr_wr = wr_ext;
  assign o_ext_csr_rd = rd_ext;
  assign o_cfg_wr = i_wr && (i_port_sel == `PORT_CONFIG);
  assign o_cfg_rd = i_rd && (i_port_sel == `PORT_CONFIG);

  // ----------------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_start_pend = start_pend_ff;
    go_run = 1'b0;
    if (stop_now) begin
      nxt_state = csr_access_pkg::ST_STOPPED;
      nxt_start_pend = 1'b0;
    end else if (setup_w) begin
      // Setup always runs first; a start given with it waits.
      nxt_state = csr_access_pkg::ST_SETUP;
      nxt_start_pend = run_w;
    end else begin
      case (state_ff)
        csr_access_pkg::ST_STOPPED, csr_access_pkg::ST_READY: begin
          if (run_w) begin
            nxt_state = csr_access_pkg::ST_RUNNING;
            go_run = 1'b1;
          end
        end
        csr_access_pkg::ST_SETUP: begin
          if (run_w) begin
            nxt_start_pend = 1'b1;
          end
          if (i_setup_read_done) begin
            if (start_pend_ff || run_w) begin
              nxt_state = csr_access_pkg::ST_RUNNING;
              go_run = 1'b1;
            end else begin
              nxt_state = csr_access_pkg::ST_READY;
            end
            nxt_start_pend = 1'b0;
          end
        end
        csr_access_pkg::ST_RUNNING: begin
          nxt_state = csr_access_pkg::ST_RUNNING;
        end
        default: begin
          nxt_state = csr_access_pkg::ST_STOPPED;
        end
      endcase
    end

    nxt_stop = stop_ff;
    if (stop_now) begin
      nxt_stop = 1'b1;
    end else if (run_w || setup_w) begin
      nxt_stop = 1'b0;
    end
    nxt_run = stop_now ? 1'b0 : (run_ff || run_w);
    nxt_setup_req = stop_now ? 1'b0 : (setup_req_ff || setup_w);

    nxt_rx_active = rx_active_ff;
    nxt_tx_active = tx_active_ff;
    if (stop_now) begin
      nxt_rx_active = 1'b0;
      nxt_tx_active = 1'b0;
    end else if (go_run) begin
      nxt_rx_active = !i_receive_disable;
      nxt_tx_active = !i_transmit_disable;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_ff <= csr_access_pkg::ST_STOPPED;
      start_pend_ff <= 1'b0;
      stop_ff <= 1'b1;
      run_ff <= 1'b0;
      setup_req_ff <= 1'b0;
      rx_active_ff <= 1'b0;
      tx_active_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      start_pend_ff <= nxt_start_pend;
      stop_ff <= nxt_stop;
      run_ff <= nxt_run;
      setup_req_ff <= nxt_setup_req;
      rx_active_ff <= nxt_rx_active;
      tx_active_ff <= nxt_tx_active;
    end
  end

  assign o_setup_req = (state_ff == csr_access_pkg::ST_SETUP);
  assign o_running = (state_ff == csr_access_pkg::ST_RUNNING);
  assign o_stopped = stop_ff;

  // ----------------------------------------------------------------------
  // Status flags, interrupt, transmit demand, index and mask
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_index = index_ff;
    if (i_wr && (i_port_sel == `PORT_INDEX)) begin
      nxt_index = i_wdata[6:0];
    end
    nxt_mask = mask_ff;
    if (wr_mask) begin
      nxt_mask = i_wdata & `MASK_WR;
    end

    nxt_babble = flag_next(babble_ff, evt.babble, wr_status && i_wdata[`B_BABBLE],
                           stop_now);
    nxt_coll = flag_next(coll_ff, evt.coll_err, wr_status && i_wdata[`B_COLL],
                         stop_now);
    nxt_missed = flag_next(missed_ff, i_rx_discard, wr_status && i_wdata[`B_MISSED],
                           stop_now);
    nxt_memerr = flag_next(memerr_ff, evt.mem_err, wr_status && i_wdata[`B_MEMERR],
                           stop_now);
    nxt_rxevt = flag_next(rxevt_ff, i_rx_done, wr_status && i_wdata[`B_RXEVT],
                          stop_now);
    nxt_txevt = flag_next(txevt_ff, i_tx_done, wr_status && i_wdata[`B_TXEVT],
                          stop_now);
    nxt_setup = flag_next(setup_ff, i_setup_read_done, wr_status && i_wdata[`B_SETUP],
                          stop_now);

    // Collision error is deliberately absent from the interrupt sources.
    irq_src = (babble_ff && !mask_ff[`B_BABBLE]) ||
              (missed_ff && !mask_ff[`B_MISSED]) ||
              (memerr_ff && !mask_ff[`B_MEMERR]) ||
              (rxevt_ff && !mask_ff[`B_RXEVT]) ||
              (txevt_ff && !mask_ff[`B_TXEVT]) ||
              (setup_ff && !mask_ff[`B_SETUP]) ||
              i_other_irq;
    nxt_irq_flag = irq_src && !stop_now;

    nxt_irq_en = irq_en_ff;
    if (stop_now) begin
      nxt_irq_en = 1'b0;
    end else if (wr_status) begin
      nxt_irq_en = i_wdata[`B_IRQ_EN];
    end

    // Without an active transmitter the demand drops with no ring access.
    nxt_tx_demand = flag_next(tx_demand_ff, wr_status && i_wdata[`B_DEMAND],
                              i_tx_desc_fetch || !tx_active_ff, stop_now);
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      index_ff <= `INDEX_RST;
      mask_ff <= `MASK_RST;
      babble_ff <= 1'b0;
      coll_ff <= 1'b0;
      missed_ff <= 1'b0;
      memerr_ff <= 1'b0;
      rxevt_ff <= 1'b0;
      txevt_ff <= 1'b0;
      setup_ff <= 1'b0;
      irq_flag_ff <= 1'b0;
      irq_en_ff <= 1'b0;
      tx_demand_ff <= 1'b0;
    end else begin
      index_ff <= nxt_index;
      mask_ff <= nxt_mask;
      babble_ff <= nxt_babble;
      coll_ff <= nxt_coll;
      missed_ff <= nxt_missed;
      memerr_ff <= nxt_memerr;
      rxevt_ff <= nxt_rxevt;
      txevt_ff <= nxt_txevt;
      setup_ff <= nxt_setup;
      irq_flag_ff <= nxt_irq_flag;
      irq_en_ff <= nxt_irq_en;
      tx_demand_ff <= nxt_tx_demand;
    end
  end

  assign o_irq = irq_en_ff && irq_flag_ff;
  assign o_tx_poll_now = tx_demand_ff && tx_active_ff;

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  always_comb begin
    err_sum = babble_ff || coll_ff || missed_ff || memerr_ff;
    status_word = {err_sum, babble_ff, coll_ff, missed_ff, memerr_ff, rxevt_ff,
                   txevt_ff, setup_ff, irq_flag_ff, irq_en_ff, rx_active_ff,
                   tx_active_ff, tx_demand_ff, stop_ff, run_ff, setup_req_ff};
    nxt_rdata = rdata_ff;
    if (i_rd) begin
      case (i_port_sel)
        `PORT_INDEX: nxt_rdata = {9'h000, index_ff};
        `PORT_MAIN: begin
          if (index_ff == `IDX_STATUS_COMMAND) begin
            nxt_rdata = status_word;
          end else if (index_ff == `IDX_MASK) begin
            nxt_rdata = mask_ff;
          end else begin
            nxt_rdata = i_ext_csr_rdata;
          end
        end
        `PORT_CONFIG: nxt_rdata = i_cfg_rdata;
        default: nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_ff <= 16'h0000;
      rd_valid_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      rd_valid_ff <= i_rd;
    end
  end

  assign o_rdata = rdata_ff;
  assign o_rd_valid = rd_valid_ff;

endmodule

// file: tb/csr_access_chk.sv
// Checker for the indirect status block, bound to its top module.
// Assumes host strobes change only just after rising edges of i_clk.
`timescale 1ns/1ps
module csr_access_chk #(
  parameter int DMA_TIMEOUT_CYC = 20
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [1:0] i_port_sel,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] i_wdata,
  input wire logic [15:0] i_cfg_rdata,
  input wire logic [15:0] o_rdata,
  input wire logic o_rd_valid,
  input wire logic [6:0] o_ext_index,
  input wire logic o_ext_csr_rd,
  input wire logic o_cfg_wr,
  input wire logic o_setup_req,
  input wire logic o_running,
  input wire logic o_stopped,
  input wire logic o_tx_poll_now,
  input wire logic o_irq
);
  // ----------------------------------------------------------------------
  // Host accesses
  // ----------------------------------------------------------------------
  logic [6:0] wd_lo;
  assign wd_lo = i_wdata[6:0];
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_stat_wr;
    i_wr && i_port_sel == 2'h1 && o_ext_index == 7'h00;
  endsequence
  AST_RD_ANSWER: assert property (i_rd |=> o_rd_valid)
    else $error("read without valid");
  AST_NO_ANSWER: assert property (!i_rd |=> !o_rd_valid)
    else $error("valid without read");
  AST_INDEX: assert property (i_wr && i_port_sel == 2'h0 |=> o_ext_index == $past(wd_lo))
    else $error("index not stored");
  AST_PORT3: assert property (i_rd && i_port_sel == 2'h3 |=> o_rdata == 16'h0000)
    else $error("unmapped port read not zero");
  AST_CFG_RD: assert property (i_rd && i_port_sel == 2'h2 |=> o_rdata == $past(i_cfg_rdata))
    else $error("config read data wrong");
  AST_CFG_STROBE: assert property (o_cfg_wr == (i_wr && i_port_sel == 2'h2))
    else $error("config write strobe wrong");
  AST_EXT_RD: assert property (o_ext_csr_rd |-> i_rd && i_port_sel == 2'h1 &&
      !(o_ext_index inside {7'h00, 7'h03}))
    else $error("external read strobe wrong");
  // ----------------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------------
  AST_STOP: assert property (s_stat_wr ##0 i_wdata[2] |=>
      o_stopped && !o_running && !o_irq && !o_tx_poll_now)
    else $error("stop did not quiesce");
  AST_RUN: assert property (s_stat_wr ##0 o_stopped && i_wdata[2:0] == 3'h2 |=>
      o_running && !o_stopped)
    else $error("start did not run");
  // The setup read may finish one cycle later, so only the first cycle is fixed.
  AST_SETUP: assert property (s_stat_wr ##0 o_stopped && i_wdata[2:0] == 3'h3 |=>
      o_setup_req && !o_running)
    else $error("setup did not come first");
  AST_IRQ_OFF: assert property (s_stat_wr ##0 !i_wdata[6] |=> !o_irq)
    else $error("irq without enable");
  AST_POLL: assert property (o_tx_poll_now |-> o_running && !o_stopped)
    else $error("poll while not running");
endmodule

bind indirect_csr_status_access csr_access_chk #(.DMA_TIMEOUT_CYC(DMA_TIMEOUT_CYC)) u_chk (
  .i_clk, .i_rstn, .i_port_sel, .i_wr, .i_rd, .i_wdata, .i_cfg_rdata, .o_rdata,
  .o_rd_valid, .o_ext_index, .o_ext_csr_rd, .o_cfg_wr, .o_setup_req, .o_running,
  .o_stopped, .o_tx_poll_now, .o_irq
);

// file: tb/ext_reg_model.sv
// External register files behind the main and config data ports.
// Assumes strobes are one-cycle pulses and read data is taken combinationally.
`timescale 1ns/1ps
module ext_reg_model (
  input wire logic i_clk,
  input wire logic [6:0] i_index,
  input wire logic i_csr_wr,
  input wire logic i_csr_rd,
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_csr_rdata,
  output logic [15:0] o_cfg_rdata
);
  logic [15:0] csr_mem [128];
  logic [15:0] cfg_mem [128];
  always_ff @(posedge i_clk) begin
    if (i_csr_wr) begin
      csr_mem[i_index] <= i_wdata;
    end
    if (i_cfg_wr) begin
      cfg_mem[i_index] <= i_wdata;
    end
  end
  // Outside a read the lines carry the inverse, so a late sample never matches.
  assign o_csr_rdata = i_csr_rd ? csr_mem[i_index] : ~csr_mem[i_index];
  assign o_cfg_rdata = i_cfg_rd ? cfg_mem[i_index] : ~cfg_mem[i_index];
endmodule

// file: tb/indirect_csr_status_access_tb.sv
// Self-checking bench for the indirect status block.
// Assumes a 125 MHz clock and the register model in ext_reg_model.
`timescale 1ns/1ps
module indirect_csr_status_access_tb;
  logic i_clk, i_rstn, i_wr, i_rd, i_tx_byte, i_tx_end, i_aui_sel, i_dma_req;
  logic i_transmitting, i_tp_link_fail;
  logic i_rx_discard, i_rx_done, i_tx_done, i_setup_read_done, i_tx_desc_fetch;
  logic i_receive_disable, i_transmit_disable, o_rd_valid, o_setup_req, o_running;
  logic o_stopped, o_tx_poll_now, o_irq, ext_wr, ext_rd, cfg_wr, cfg_rd;
  logic [1:0] i_port_sel;
  logic [6:0] ext_index;
  logic [15:0] i_wdata, o_rdata, ext_rdata, cfg_rdata, ext_wdata;
  logic [15:0] ev_exp [8] = '{16'h04F2, 16'h02F2, 16'h01F2, 16'h90F2,
                              16'hC0F2, 16'h88F2, 16'hA072, 16'hA072};
  int err_count = 0;
  int n_tests = 0;

  indirect_csr_status_access #(.DMA_TIMEOUT_CYC(20)) dut (
    .i_clk, .i_rstn, .i_port_sel, .i_wr, .i_rd, .i_wdata, .o_rdata, .o_rd_valid,
    .o_ext_index(ext_index), .o_ext_csr_wr(ext_wr), .o_ext_csr_rd(ext_rd),
    .i_ext_csr_rdata(ext_rdata), .o_cfg_wr(cfg_wr), .o_cfg_rd(cfg_rd),
    .i_cfg_rdata(cfg_rdata), .o_ext_wdata(ext_wdata), .i_tx_byte, .i_tx_end,
    .i_transmitting, .i_aui_sel, .i_aui_col(1'h0), .i_tp_link_fail,
    .i_dma_req, .i_dma_ack(1'h0), .i_rx_discard, .i_rx_done, .i_tx_done,
    .i_setup_read_done, .i_tx_desc_fetch, .i_other_irq(1'h0), .i_receive_disable,
    .i_transmit_disable, .o_setup_req, .o_running, .o_stopped, .o_tx_poll_now, .o_irq
  );

  ext_reg_model ext (
    .i_clk, .i_index(ext_index), .i_csr_wr(ext_wr), .i_csr_rd(ext_rd),
    .i_cfg_wr(cfg_wr), .i_cfg_rd(cfg_rd), .i_wdata(ext_wdata),
    .o_csr_rdata(ext_rdata), .o_cfg_rdata(cfg_rdata)
  );

  // ----------------------------------------------------------------------
  // Host access and check tasks
  // ----------------------------------------------------------------------
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  // The extra edge keeps two writes from touching the strobe in one step.
  task wr(input logic [1:0] s, input logic [15:0] d);
    i_port_sel <= s;
    i_wdata <= d;
    i_wr <= 1'h1;
    @(posedge i_clk);
    i_wr <= 1'h0;
    @(posedge i_clk);
  endtask

  task rd(input logic [1:0] s, input logic [15:0] e, input string n);
    i_port_sel <= s;
    i_rd <= 1'h1;
    @(posedge i_clk);
    i_rd <= 1'h0;
    #1;
    chk("rd_valid", {15'h0000, o_rd_valid}, 16'h0001);
    chk(n, o_rdata, e);
    @(posedge i_clk);
  endtask

  // Long events hold their input for a count of edges; then the line settles.
  task fire(input int k);
    case (k)
      0: i_rx_done <= 1'h1;
      1: i_tx_done <= 1'h1;
      2: i_setup_read_done <= 1'h1;
      3: i_rx_discard <= 1'h1;
      4: i_tx_byte <= 1'h1;
      5: i_dma_req <= 1'h1;
      6: begin
        i_aui_sel <= 1'h1;
        i_tx_end <= 1'h1;
      end
      default: begin
        i_transmitting <= 1'h1;
        i_tp_link_fail <= 1'h1;
      end
    endcase
    repeat (k == 4 ? 1519 : k == 5 ? 25 : 1) @(posedge i_clk);
    {i_rx_done, i_tx_done, i_setup_read_done, i_rx_discard} <= 4'h0;
    {i_tx_byte, i_dma_req, i_tx_end, i_transmitting, i_tp_link_fail} <= 5'h00;
    repeat (260) @(posedge i_clk);
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------------------------------------
  initial begin
    i_clk = 1'h0;
    forever #4 i_clk = ~i_clk;
  end

  initial begin
    #400000;
    err_count++;
    end_sim;
  end

  initial begin
    {i_rstn, i_wr, i_rd, i_tx_byte, i_tx_end, i_aui_sel, i_dma_req} = 7'h00;
    {i_rx_discard, i_rx_done, i_tx_done, i_setup_read_done, i_tx_desc_fetch} = 5'h00;
    {i_receive_disable, i_transmit_disable, i_transmitting, i_tp_link_fail} = 4'h0;
    i_port_sel = 2'h0;
    i_wdata = 16'h0000;
    repeat (10) @(posedge i_clk);
    i_rstn <= 1'h1;
    @(posedge i_clk);
    rd(2'h0, 16'h0000, "index");
    rd(2'h1, 16'h0004, "status");
    wr(2'h0, 16'hFF85);
    rd(2'h0, 16'h0005, "index");
    wr(2'h1, 16'h1234);
    wr(2'h2, 16'hABCD);
    wr(2'h3, 16'hFFFF);
    rd(2'h1, 16'h1234, "main");
    rd(2'h2, 16'hABCD, "config");
    rd(2'h3, 16'h0000, "unmapped");
    rd(2'h0, 16'h0005, "index");
    wr(2'h0, 16'h0003);
    wr(2'h1, 16'hFFFF);
    rd(2'h1, 16'h5F00, "mask");
    wr(2'h1, 16'h0000);
    $display("test ports done");
    wr(2'h0, 16'h0000);
    wr(2'h1, 16'h0042);
    rd(2'h1, 16'h0072, "start");
    for (int k = 0; k < 8; k++) begin
      fire(k);
      rd(2'h1, ev_exp[k], "event");
      chk("irq", {15'h0000, o_irq}, {15'h0000, ev_exp[k][7]});
      wr(2'h1, 16'h0040);
      rd(2'h1, ev_exp[k], "kept");
      wr(2'h1, (ev_exp[k] & 16'h7F00) | 16'h0040);
      rd(2'h1, 16'h0072, "cleared");
    end
    $display("test events done");
    wr(2'h0, 16'h0003);
    wr(2'h1, 16'h0400);
    wr(2'h0, 16'h0000);
    fire(0);
    rd(2'h1, 16'h0472, "masked");
    chk("irq", {15'h0000, o_irq}, 16'h0000);
    wr(2'h1, 16'h0440);
    wr(2'h1, 16'h0048);
    chk("poll", {15'h0000, o_tx_poll_now}, 16'h0001);
    i_tx_desc_fetch <= 1'h1;
    @(posedge i_clk);
    i_tx_desc_fetch <= 1'h0;
    @(posedge i_clk);
    chk("poll", {15'h0000, o_tx_poll_now}, 16'h0000);
    rd(2'h1, 16'h0072, "fetched");
    $display("test mask and demand done");
    wr(2'h1, 16'h0004);
    rd(2'h1, 16'h0004, "stop");
    wr(2'h1, 16'h0008);
    rd(2'h1, 16'h0004, "idle demand");
    wr(2'h0, 16'h0003);
    rd(2'h1, 16'h0400, "mask kept");
    wr(2'h1, 16'h0000);
    wr(2'h0, 16'h0000);
    i_transmit_disable <= 1'h1;
    wr(2'h1, 16'h0003);
    rd(2'h1, 16'h0003, "setup");
    fire(2);
    rd(2'h1, 16'h01A3, "ready");
    chk("irq", {15'h0000, o_irq}, 16'h0000);
    $display("test setup done");
    end_sim;
  end
endmodule
